// File: logic/cltst_pkg.sv
package cltst_pkg;
    // ==========================================================
    // Sizes
    localparam int unsigned NPIN  = 14;
    localparam int unsigned NTEST = 12;
    localparam int unsigned DW    = 32;
    localparam int unsigned PW    = 14;
    localparam int unsigned AW    = 9;

    // ==========================================================
    // Register byte addresses
    localparam logic [8:0] A_CTRL  = 9'h000;
    localparam logic [8:0] A_PINS  = 9'h004;
    localparam logic [8:0] A_OFFS  = 9'h008;
    localparam logic [8:0] A_CPASS = 9'h00c;
    localparam logic [8:0] A_CFAIL = 9'h010;
    localparam logic [8:0] A_STAT  = 9'h014;
    localparam logic [8:0] A_TBASE = 9'h040;
    localparam logic [8:0] A_TEND  = 9'h1c0;

    // Per-test word fields, address bits [4:2]
    localparam logic [2:0] F_CFG  = 3'h0;
    localparam logic [2:0] F_UP   = 3'h1;
    localparam logic [2:0] F_LOW  = 3'h2;
    localparam logic [2:0] F_PPAT = 3'h3;
    localparam logic [2:0] F_FPAT = 3'h4;
    localparam logic [2:0] F_UPAT = 3'h5;
    localparam logic [2:0] F_LPAT = 3'h6;

    // CTRL bits
    localparam int unsigned C_EN   = 0;
    localparam int unsigned C_SORT = 1;
    localparam int unsigned C_ACLR = 2;
    localparam int unsigned C_UEND = 3;
    localparam int unsigned C_OC   = 4;
    localparam int unsigned C_CLR  = 8;
    localparam int unsigned CTRL_W = 5;

    // Per-test CFG bits
    localparam int unsigned T_EN    = 0;
    localparam int unsigned T_LIMIT = 1;
    localparam int unsigned T_FIN   = 2;
    localparam int unsigned T_FEED  = 3;
    localparam int unsigned TCFG_W  = 5;

    // Reset values and pin limit
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [3:0] PIN_RST  = 4'h0;
    localparam logic [3:0] PIN_MAX  = 4'he;

    // Timing
    localparam int unsigned CLK_NS  = 10;
    localparam int unsigned EOT_NS  = 100;
    localparam int unsigned EOT_CYC = (EOT_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {FEED_MATH, FEED_VOLT, FEED_AMP, FEED_OHM} cltst_feed_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_EOT} cltst_st_t;
endpackage : cltst_pkg

// File: logic/cltst_sorter.sv
// Behaviour
// - Composite enable and selectable grading or sorting mode.
// - Auto clear wipes results and pattern pins at each test start.
// - Grading drives result at once or at sequence end, per update setting.
// - With offset cancel, judge raw data minus offset.
// - Offset register takes any signed value in its range.
// - Grading pass drives the composite pass pattern.
// - Busy and end-of-test outputs on their own assigned pins.
// - Pin settings are 0 to 14; 0 means unused.
// - Pattern sits on contiguous pins, bit 0 on lowest pin.
// - Each test judges math, volts, amps or volts over amps.
// - Twelve tests numbered 1 to 12; number is the bin.
// - Each test has enable and compliance or limit function.
// - Compliance test fails entering, or with other setting leaving, compliance.
// - Grading compliance test that fails drives its fail pattern.
// - Grading limit test above upper limit drives upper pattern.
// - Grading limit test below lower limit drives lower pattern.
// - Sorting drives the pass pattern of the selected passing bin.
// - Every pattern goes only to the assigned pattern pin group.
module cltst_sorter (
    input  wire logic                  clk_i,
    input  wire logic                  rstn_i,
    input  wire logic [8:0]            addr_i,
    input  wire logic [31:0]           wdata_i,
    input  wire logic                  we_i,
    input  wire logic                  re_i,
    output logic      [31:0]           rdata_o,
    input  wire logic signed [31:0]    math_i,
    input  wire logic signed [31:0]    volt_i,
    input  wire logic signed [31:0]    amp_i,
    input  wire logic                  compliance_i,
    input  wire logic                  meas_valid_i,
    input  wire logic                  meas_last_i,
    input  wire logic [13:0]           digital_io_line_i,
    output logic      [13:0]           digital_io_line_o,
    output logic      [13:0]           digital_io_line_oe_n_o
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [4:0]               ctrl;
        logic [3:0]               pfirst;
        logic [3:0]               pwidth;
        logic [3:0]               pbusy;
        logic [3:0]               psot;
        logic [3:0]               peot;
        logic signed [31:0]       offs;
        logic [13:0]              cpass;
        logic [13:0]              cfail;
        logic [11:0][4:0]         tcfg;
        logic [11:0][31:0]        tup;
        logic [11:0][31:0]        tlow;
        logic [11:0][13:0]        tppat;
        logic [11:0][13:0]        tfpat;
        logic [11:0][13:0]        tupat;
        logic [11:0][13:0]        tlpat;
        cltst_pkg::cltst_st_t     st;
        logic [13:0]              pat;
        logic [3:0]               bin;
        logic                     passed;
        logic                     rvalid;
        logic                     seq_fail;
        logic [13:0]              seq_pat;
        logic [3:0]               seq_bin;
        logic [13:0]              sync1;
        logic [13:0]              sync2;
        logic                     sot_prev;
        logic [3:0]               eot_cnt;
        logic [31:0]              rdata;
    } cltst_state_t;

    cltst_state_t q;
    cltst_state_t d;

    // ==========================================================
    // Data sources and per-test judgement
    logic signed [31:0] ohm;
    logic        [11:0] tfail;
    logic        [11:0] tpass;
    logic [11:0][13:0]  tfpat_sel;
    logic [11:0][31:0]  tx;

    assign ohm = (amp_i == 32'sh0) ? 32'sh7fffffff : volt_i / amp_i;

    for (genvar k = 0; k < 12; k++) begin : g_test
        logic signed [31:0] raw;
        logic               hi;
        logic               lo;
        logic               cfl;
        always_comb begin
            unique case (cltst_pkg::cltst_feed_t'(q.tcfg[k][cltst_pkg::T_FEED +: 2]))
                cltst_pkg::FEED_MATH: raw = math_i;
                cltst_pkg::FEED_VOLT: raw = volt_i;
                cltst_pkg::FEED_AMP:  raw = amp_i;
                cltst_pkg::FEED_OHM:  raw = ohm;
            endcase
        end
        assign tx[k] = q.ctrl[cltst_pkg::C_OC] ? raw - q.offs : raw;
        assign hi    = $signed(tx[k]) > $signed(q.tup[k]);
        assign lo    = $signed(tx[k]) < $signed(q.tlow[k]);
        assign cfl   = q.tcfg[k][cltst_pkg::T_FIN] ? compliance_i : !compliance_i;
        assign tfail[k] = q.tcfg[k][cltst_pkg::T_EN]
                        & (q.tcfg[k][cltst_pkg::T_LIMIT] ? (hi | lo) : cfl);
        assign tpass[k] = q.tcfg[k][cltst_pkg::T_EN] & !tfail[k];
        assign tfpat_sel[k] = !q.tcfg[k][cltst_pkg::T_LIMIT] ? q.tfpat[k]
                            : hi ? q.tupat[k] : q.tlpat[k];
    end

    // First failing and first passing test by index
    logic        g_fail;
    logic [13:0] g_pat;
    logic [3:0]  g_bin;
    logic        s_pass;
    logic [13:0] s_pat;
    logic [3:0]  s_bin;

    always_comb begin
        g_fail = 1'b0;
        g_pat  = 14'h0000;
        g_bin  = 4'h0;
        s_pass = 1'b0;
        s_pat  = 14'h0000;
        s_bin  = 4'h0;
        for (int k = 11; k >= 0; k--) begin
            if (tfail[k]) begin
                g_fail = 1'b1;
                g_pat  = tfpat_sel[k];
                g_bin  = 4'(k + 1);
            end
            if (tpass[k]) begin
                s_pass = 1'b1;
                s_pat  = q.tppat[k];
                s_bin  = 4'(k + 1);
            end
        end
    end

    // ==========================================================
    // Start-of-test pin and register read data
    logic       sot_lvl;
    logic       sot_fall;
    logic [3:0] tidx;
    logic [2:0] tfld;
    logic       tsel;
    logic [31:0] rd_val;

    assign sot_lvl  = (q.psot == 4'h0) ? 1'b1 : q.sync2[q.psot - 4'h1];
    assign sot_fall = q.sot_prev & !sot_lvl;
    assign tsel     = addr_i >= cltst_pkg::A_TBASE && addr_i < cltst_pkg::A_TEND;
    assign tidx     = 4'((addr_i - cltst_pkg::A_TBASE) >> 5);
    assign tfld     = addr_i[4:2];

    function automatic logic [3:0] pin_ok(input logic [31:0] v);
        pin_ok = (v <= 32'(cltst_pkg::PIN_MAX)) ? v[3:0] : cltst_pkg::PIN_RST;
    endfunction : pin_ok

    always_comb begin
        rd_val = 32'h0;
        if (tsel) begin
            unique case (tfld)
                cltst_pkg::F_CFG:  rd_val = 32'(q.tcfg[tidx]);
                cltst_pkg::F_UP:   rd_val = q.tup[tidx];
                cltst_pkg::F_LOW:  rd_val = q.tlow[tidx];
                cltst_pkg::F_PPAT: rd_val = 32'(q.tppat[tidx]);
                cltst_pkg::F_FPAT: rd_val = 32'(q.tfpat[tidx]);
                cltst_pkg::F_UPAT: rd_val = 32'(q.tupat[tidx]);
                cltst_pkg::F_LPAT: rd_val = 32'(q.tlpat[tidx]);
                default:           rd_val = 32'h0;
            endcase
        end else begin
            unique case (addr_i)
                cltst_pkg::A_CTRL:  rd_val = 32'(q.ctrl);
                cltst_pkg::A_PINS:  rd_val = {12'h000, q.peot, q.psot, q.pbusy,
                                              q.pwidth, q.pfirst};
                cltst_pkg::A_OFFS:  rd_val = q.offs;
                cltst_pkg::A_CPASS: rd_val = 32'(q.cpass);
                cltst_pkg::A_CFAIL: rd_val = 32'(q.cfail);
                cltst_pkg::A_STAT:  rd_val = {10'h000, q.pat, q.bin, q.passed,
                                              q.rvalid, 1'b0, q.st == cltst_pkg::ST_RUN};
                default:            rd_val = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // Next state
    logic drive;
    logic res_fail;

    always_comb begin
        d          = q;
        drive      = 1'b0;
        res_fail   = q.seq_fail | g_fail;
        d.sync1    = digital_io_line_i;
        d.sync2    = q.sync1;
        d.sot_prev = sot_lvl;
        d.rdata    = re_i ? rd_val : 32'h0;
        if (we_i) begin
            if (tsel) begin
                unique case (tfld)
                    cltst_pkg::F_CFG:  d.tcfg[tidx]  = wdata_i[4:0];
                    cltst_pkg::F_UP:   d.tup[tidx]   = wdata_i;
                    cltst_pkg::F_LOW:  d.tlow[tidx]  = wdata_i;
                    cltst_pkg::F_PPAT: d.tppat[tidx] = wdata_i[13:0];
                    cltst_pkg::F_FPAT: d.tfpat[tidx] = wdata_i[13:0];
                    cltst_pkg::F_UPAT: d.tupat[tidx] = wdata_i[13:0];
                    cltst_pkg::F_LPAT: d.tlpat[tidx] = wdata_i[13:0];
                    default: ;
                endcase
            end else begin
                unique case (addr_i)
                    cltst_pkg::A_CTRL: begin
                        d.ctrl = wdata_i[4:0];
                        if (wdata_i[cltst_pkg::C_CLR]) begin
                            d.pat    = 14'h0000;
                            d.bin    = 4'h0;
                            d.passed = 1'b0;
                            d.rvalid = 1'b0;
                        end
                    end
                    cltst_pkg::A_PINS: begin
                        d.pfirst = pin_ok(32'(wdata_i[3:0]));
                        d.pwidth = wdata_i[7:4];
                        d.pbusy  = pin_ok(32'(wdata_i[11:8]));
                        d.psot   = pin_ok(32'(wdata_i[15:12]));
                        d.peot   = pin_ok(32'(wdata_i[19:16]));
                    end
                    cltst_pkg::A_OFFS:  d.offs  = wdata_i;
                    cltst_pkg::A_CPASS: d.cpass = wdata_i[13:0];
                    cltst_pkg::A_CFAIL: d.cfail = wdata_i[13:0];
                    default: ;
                endcase
            end
        end
        unique case (q.st)
            cltst_pkg::ST_IDLE: begin
                if (sot_fall && q.ctrl[cltst_pkg::C_EN]) begin
                    d.st       = cltst_pkg::ST_RUN;
                    d.seq_fail = 1'b0;
                    if (q.ctrl[cltst_pkg::C_ACLR]) begin
                        d.pat    = 14'h0000;
                        d.bin    = 4'h0;
                        d.passed = 1'b0;
                        d.rvalid = 1'b0;
                    end
                end
            end
            cltst_pkg::ST_RUN: begin
                if (meas_valid_i && !q.ctrl[cltst_pkg::C_SORT]) begin
                    if (meas_last_i || (g_fail && !q.ctrl[cltst_pkg::C_UEND])) begin
                        drive    = 1'b1;
                        d.passed = !res_fail;
                        d.pat    = !res_fail ? q.cpass
                                 : q.seq_fail ? q.seq_pat : g_pat;
                        d.bin    = !res_fail ? 4'h0 : q.seq_fail ? q.seq_bin : g_bin;
                    end else if (g_fail && !q.seq_fail) begin
                        d.seq_fail = 1'b1;
                        d.seq_pat  = g_pat;
                        d.seq_bin  = g_bin;
                    end
                end else if (meas_valid_i && meas_last_i) begin
                    drive    = 1'b1;
                    d.passed = s_pass;
                    d.pat    = s_pass ? s_pat : q.cfail;
                    d.bin    = s_bin;
                end
                if (drive) begin
                    d.rvalid  = 1'b1;
                    d.st      = cltst_pkg::ST_EOT;
                    d.eot_cnt = 4'(cltst_pkg::EOT_CYC - 1);
                end
            end
            cltst_pkg::ST_EOT: begin
                d.eot_cnt = q.eot_cnt - 4'h1;
                if (q.eot_cnt == 4'h0) begin
                    d.st = cltst_pkg::ST_IDLE;
                end
            end
            default: d.st = cltst_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q          <= '0;
            q.ctrl     <= cltst_pkg::CTRL_RST;
            q.st       <= cltst_pkg::ST_IDLE;
            q.sync1    <= 14'h3fff;
            q.sync2    <= 14'h3fff;
            q.sot_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Pins
    logic busy_n;
    logic eot_n;

    assign busy_n  = q.st != cltst_pkg::ST_RUN;
    assign eot_n   = q.st != cltst_pkg::ST_EOT;
    assign rdata_o = q.rdata;

    for (genvar p = 0; p < 14; p++) begin : g_pin
        logic [4:0] pn;
        logic [3:0] off;
        logic       grp;
        logic       isb;
        logic       ise;
        assign pn  = 5'(p + 1);
        assign off = 4'(pn - 5'(q.pfirst));
        assign grp = q.pfirst != 4'h0 && pn >= 5'(q.pfirst)
                  && pn < 5'(q.pfirst) + 5'(q.pwidth);
        assign isb = 5'(q.pbusy) == pn;
        assign ise = 5'(q.peot) == pn;
        assign digital_io_line_o[p] = grp ? q.pat[off] : isb ? busy_n : ise ? eot_n : 1'b0;
        assign digital_io_line_oe_n_o[p] = !(grp | isb | ise);
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_start;
        q.st == cltst_pkg::ST_IDLE && sot_fall && q.ctrl[cltst_pkg::C_EN]
            |=> !busy_n && eot_n;
    endproperty
    a_start: assert property (p_start) else $error("busy not raised on start");

    property p_eot;
        drive |=> busy_n ##0 !eot_n [*8];
    endproperty
    a_eot: assert property (p_eot) else $error("end pulse missing");

    property p_aclr;
        q.st == cltst_pkg::ST_IDLE && sot_fall && q.ctrl[cltst_pkg::C_EN]
            && q.ctrl[cltst_pkg::C_ACLR] && !we_i |=> !q.rvalid && q.pat == 14'h0000;
    endproperty
    a_aclr: assert property (p_aclr) else $error("auto clear failed");

    property p_imm;
        q.st == cltst_pkg::ST_RUN && meas_valid_i && g_fail && !q.seq_fail
            && !q.ctrl[cltst_pkg::C_SORT] && !q.ctrl[cltst_pkg::C_UEND]
            |=> q.pat == $past(g_pat) && !q.passed;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate fail not driven");

    property p_gpass;
        drive && !q.ctrl[cltst_pkg::C_SORT] && !res_fail |=> q.pat == $past(q.cpass);
    endproperty
    a_gpass: assert property (p_gpass) else $error("pass pattern wrong");

    property p_sort;
        drive && q.ctrl[cltst_pkg::C_SORT] && s_pass
            |=> q.pat == $past(s_pat) && q.bin == $past(s_bin) && q.passed;
    endproperty
    a_sort: assert property (p_sort) else $error("sort bin wrong");

    property p_offs;
        q.ctrl[cltst_pkg::C_OC] && q.tcfg[0][cltst_pkg::T_FEED +: 2] == 2'h1
            |-> tx[0] == volt_i - q.offs;
    endproperty
    a_offs: assert property (p_offs) else $error("offset not removed");

    property p_pins;
        q.pfirst <= cltst_pkg::PIN_MAX && q.psot <= cltst_pkg::PIN_MAX
            && q.pbusy <= cltst_pkg::PIN_MAX && q.peot <= cltst_pkg::PIN_MAX;
    endproperty
    a_pins: assert property (p_pins) else $error("pin setting out of range");

    property p_lsb;
        q.pfirst != 4'h0 && q.pwidth != 4'h0
            |-> digital_io_line_o[q.pfirst - 4'h1] == q.pat[0]
                && !digital_io_line_oe_n_o[q.pfirst - 4'h1];
    endproperty
    a_lsb: assert property (p_lsb) else $error("pattern lsb misplaced");

    c_grade_fail: cover property (drive && !q.ctrl[cltst_pkg::C_SORT] && res_fail);
    c_grade_pass: cover property (drive && !q.ctrl[cltst_pkg::C_SORT] && !res_fail);
    c_sort_bin:   cover property (drive && q.ctrl[cltst_pkg::C_SORT] && s_pass);
endmodule : cltst_sorter

// File: verification/cltst_handler.sv
// ==========================================================
// Handler on the digital I/O lines
module cltst_handler #(
    parameter int unsigned SOT_PIN = 10
) (
    input  wire logic        clk_i,
    input  wire logic [13:0] pin_o_i,
    input  wire logic [13:0] pin_oe_n_i,
    output logic      [13:0] pin_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        sot_n_q = 1'b1;
    logic [13:0] tog_q   = 14'h0000;

    always @(posedge clk_i) begin
        tog_q <= ~tog_q;
    end

    // Released lines flip every cycle; start line is ours
    always_comb begin
        for (int p = 0; p < 14; p++) begin
            if (!pin_oe_n_i[p]) begin
                pin_lvl_o[p] = pin_o_i[p];
            end else if (p == SOT_PIN - 1) begin
                pin_lvl_o[p] = sot_n_q;
            end else begin
                pin_lvl_o[p] = tog_q[p];
            end
        end
    end

    // Active-low start request, held three cycles
    task automatic start;
        @(posedge clk_i);
        sot_n_q <= 1'b0;
        repeat (3) @(posedge clk_i);
        sot_n_q <= 1'b1;
    endtask : start
endmodule : cltst_handler

// File: verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic        [7:0]  ctrl, c1, c2;
        logic signed [31:0] m, v, a;
        logic               comp;
        logic        [3:0]  pat, bin;
    } cltst_row_t;

    localparam int BUSY = 8;
    localparam int EOT  = 10;

    logic               clk_i = 1'b0;
    logic               rstn_i = 1'b0;
    logic        [8:0]  addr_i = 9'h000;
    logic        [31:0] wdata_i = 32'h0;
    logic               we_i = 1'b0;
    logic               re_i = 1'b0;
    logic        [31:0] rdata_o;
    logic signed [31:0] math_i = 32'sh0, volt_i = 32'sh0, amp_i = 32'sh0;
    logic               compliance_i = 1'b0, meas_valid_i = 1'b0, meas_last_i = 1'b0;
    logic        [13:0] lvl, dio_o, dio_oe_n;
    logic        [31:0] s;
    int                 error_cnt = 0;
    int                 total_checks = 0;

    cltst_row_t rows [16] = '{
        '{8'h05, 8'h0b, 8'h00, 0, 50, 0, 0, 4'h9, 4'h0},
        '{8'h05, 8'h0b, 8'h00, 0, 150, 0, 0, 4'h3, 4'h1},
        '{8'h05, 8'h0b, 8'h00, 0, -150, 0, 0, 4'h4, 4'h1},
        '{8'h05, 8'h13, 8'h00, 0, 0, 200, 0, 4'h3, 4'h1},
        '{8'h05, 8'h1b, 8'h00, 0, 1000, 2, 0, 4'h3, 4'h1},
        '{8'h05, 8'h03, 8'h00, -101, 0, 0, 0, 4'h4, 4'h1},
        '{8'h05, 8'h05, 8'h00, 0, 0, 0, 1, 4'h2, 4'h1},
        '{8'h05, 8'h01, 8'h00, 0, 0, 0, 0, 4'h2, 4'h1},
        '{8'h05, 8'h01, 8'h00, 0, 0, 0, 1, 4'h9, 4'h0},
        '{8'h05, 8'h0b, 8'h13, 0, 50, 200, 0, 4'h7, 4'h2},
        '{8'h05, 8'h0b, 8'h13, 0, 150, 200, 0, 4'h3, 4'h1},
        '{8'h07, 8'h0b, 8'h13, 0, 150, 0, 0, 4'h5, 4'h2},
        '{8'h07, 8'h0b, 8'h13, 0, 150, 200, 0, 4'ha, 4'h0},
        '{8'h07, 8'h0b, 8'h13, 0, 50, 0, 0, 4'h1, 4'h1},
        '{8'h15, 8'h0b, 8'h00, 0, -250, 0, 0, 4'h9, 4'h0},
        '{8'h05, 8'h0b, 8'h00, 0, -250, 0, 0, 4'h4, 4'h1}
    };

    cltst_sorter u_cltst_sorter (
        .clk_i                  (clk_i),
        .rstn_i                 (rstn_i),
        .addr_i                 (addr_i),
        .wdata_i                (wdata_i),
        .we_i                   (we_i),
        .re_i                   (re_i),
        .rdata_o                (rdata_o),
        .math_i                 (math_i),
        .volt_i                 (volt_i),
        .amp_i                  (amp_i),
        .compliance_i           (compliance_i),
        .meas_valid_i           (meas_valid_i),
        .meas_last_i            (meas_last_i),
        .digital_io_line_i      (lvl),
        .digital_io_line_o      (dio_o),
        .digital_io_line_oe_n_o (dio_oe_n)
    );

    cltst_handler #(.SOT_PIN(10)) u_cltst_handler (
        .clk_i      (clk_i),
        .pin_o_i    (dio_o),
        .pin_oe_n_i (dio_oe_n),
        .pin_lvl_o  (lvl)
    );

    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [8:0] ta(input int n, input logic [2:0] f);
        return 9'(32'h40 + (n - 1) * 32 + f * 4);
    endfunction : ta

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        @(posedge clk_i);
        we_i    <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [8:0] a, output logic [31:0] d);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge clk_i);
        re_i   <= 1'b0;
        #1;
        d = rdata_o;
        @(posedge clk_i);
    endtask : rd

    // Bounded wait for a pin level, ends just after an edge
    task automatic wait_pin(input int p, input logic v, output int n);
        n = 0;
        #1;
        while (lvl[p] !== v && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(32'(n < 40), 32'h1);
    endtask : wait_pin

    task automatic begin_test;
        int n;
        u_cltst_handler.start();
        wait_pin(BUSY, 1'b0, n);
        chk(lvl[5:2], 4'h0);
        @(posedge clk_i);
    endtask : begin_test

    task automatic meas(input logic last);
        meas_valid_i <= 1'b1;
        meas_last_i  <= last;
        @(posedge clk_i);
        meas_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask : meas

    task automatic finish_test(input logic [3:0] pat, input logic [3:0] bin);
        int n;
        wait_pin(EOT, 1'b0, n);
        chk(lvl[BUSY], 1'b1);
        wait_pin(EOT, 1'b1, n);
        // Pulse fell one edge before this task began
        chk(32'(n + 1), cltst_pkg::EOT_CYC);
        chk(lvl[5:2], pat);
        chk(dio_oe_n & 14'h3ac3, 14'h3ac3);
        @(posedge clk_i);
        rd(cltst_pkg::A_STAT, s);
        chk(s[7:4], bin);
    endtask : finish_test

    // ==========================================================
    // Stimulus
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        #200us;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        chk(dio_oe_n, 14'h3fff);
        rd(cltst_pkg::A_CTRL, s);
        chk(s, 32'h0);
        wr(cltst_pkg::A_PINS, 32'h000ba94f);
        rd(cltst_pkg::A_PINS, s);
        chk(s, 32'h000ba940);
        rd(9'h030, s);
        chk(s, 32'h0);
        wr(cltst_pkg::A_PINS, 32'h000ba943);
        wr(cltst_pkg::A_OFFS, 32'hffffff38);
        wr(cltst_pkg::A_CPASS, 32'h9);
        wr(cltst_pkg::A_CFAIL, 32'ha);
        for (int k = 0; k < 8; k++) begin
            wr(ta(k / 4 + 1, 3'(3 + k % 4)), 32'(k + 1));
        end
        for (int n = 1; n < 3; n++) begin
            wr(ta(n, cltst_pkg::F_UP), 32'd100);
            wr(ta(n, cltst_pkg::F_LOW), 32'hffffff9c);
        end
        u_cltst_handler.start();
        repeat (8) @(posedge clk_i);
        rd(cltst_pkg::A_STAT, s);
        chk(s[0], 1'b0);
        foreach (rows[i]) begin
            wr(cltst_pkg::A_CTRL, 32'(rows[i].ctrl));
            wr(ta(1, cltst_pkg::F_CFG), 32'(rows[i].c1));
            wr(ta(2, cltst_pkg::F_CFG), 32'(rows[i].c2));
            math_i       <= rows[i].m;
            volt_i       <= rows[i].v;
            amp_i        <= rows[i].a;
            compliance_i <= rows[i].comp;
            begin_test();
            meas(1'b1);
            finish_test(rows[i].pat, rows[i].bin);
        end
        // Immediate update: first failing sample ends the sequence
        wr(cltst_pkg::A_CTRL, 32'h05);
        wr(ta(1, cltst_pkg::F_CFG), 32'h0b);
        wr(ta(2, cltst_pkg::F_CFG), 32'h00);
        volt_i <= 32'sd150;
        begin_test();
        meas(1'b0);
        #1;
        chk(lvl[5:2], 4'h3);
        finish_test(4'h3, 4'h1);
        // End update: result held until the last sample
        wr(cltst_pkg::A_CTRL, 32'h0d);
        begin_test();
        meas(1'b0);
        #1;
        chk({lvl[BUSY], lvl[5:2]}, 5'h00);
        @(posedge clk_i);
        volt_i <= 32'sd50;
        meas(1'b1);
        finish_test(4'h3, 4'h1);
        // Clear command wipes result and pattern lines
        wr(cltst_pkg::A_CTRL, 32'h10d);
        rd(cltst_pkg::A_STAT, s);
        chk(s, 32'h0);
        chk(lvl[5:2], 4'h0);
        // Reset while idle releases every pin
        rstn_i <= 1'b0;
        @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        chk(dio_oe_n, 14'h3fff);
        rd(cltst_pkg::A_PINS, s);
        chk(s, 32'h0);
        report_and_stop();
    end
endmodule : testbench
